// [hw/asr_regs.svh]
// constants for the avionics serial receive ports
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH
`define ASR_CLK_HZ 125000000
`define ASR_DTU_BAUD_X10 225000
`define ASR_SAT_BAUD 4800
`define ASR_DTU_STOPS 2
`define ASR_SAT_STOPS 1
`define ASR_A429_BITS 32
`define ASR_A429_GAP_NULLS 4
`define ASR_A429_PAR_IDX 31
`define ASR_LBL_ISO5 8'hEF
`define ASR_LBL_TIME 8'h55
`define ASR_LBL_ALT 8'h84
`define ASR_LBL_TAS 8'h88
`define ASR_LBL_SAT 8'h8B
`define ASR_LBL_DATE 8'hB0
`define ASR_LBL_LAT 8'hC8
`define ASR_LBL_LON 8'hC9
`define ASR_LBL_GS 8'hCA
`define ASR_LBL_WSPD 8'hCD
`define ASR_LBL_WDIR 8'hCE
`define ASR_LBL_SATISO 8'hC4
`define ASR_LBL_SDUSTAT 8'hB8
`endif

// [hw/asr_pkg.sv]
// types shared by the avionics serial receive ports
package asr_pkg;
  typedef enum logic [1:0] {
    UART_IDLE = 2'b00,
    UART_START = 2'b01,
    UART_DATA = 2'b10,
    UART_STOP = 2'b11
  } asr_uart_state_t;
  typedef logic [7:0] asr_byte_t;
  typedef logic [31:0] asr_word_t;
endpackage

// [hw/asr_uart_rx.sv]
// asynchronous byte receiver, lsb first, configurable stop bits
`timescale 1ns/100ps
`include "asr_regs.svh"
module asr_uart_rx #(
  parameter int BIT_CYCLES = 5556,
  parameter int STOP_BITS = 1
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic rxLine,
  output asr_pkg::asr_byte_t rxData,
  output logic rxValid,
  output logic rxFrameErr
);
  import asr_pkg::*;
  localparam int CW = $clog2(BIT_CYCLES + 1);
  localparam logic [CW-1:0] HALF = CW'(BIT_CYCLES / 2 - 1);
  localparam logic [CW-1:0] FULL = CW'(BIT_CYCLES - 1);
  asr_uart_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [2:0] bit_q, bit_d;
  logic [1:0] stop_q, stop_d;
  asr_byte_t shf_q, shf_d, data_q, data_d;
  logic vld_q, vld_d, ferr_q, ferr_d, bad_q, bad_d;
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    stop_d = stop_q;
    shf_d = shf_q;
    data_d = data_q;
    bad_d = bad_q;
    vld_d = 1'b0;
    ferr_d = 1'b0;
    case (state_q)
      UART_IDLE: begin
        if (!rxLine) begin
          state_d = UART_START;
          cnt_d = HALF;
        end
      end
      UART_START: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else if (rxLine) begin
          state_d = UART_IDLE;
        end else begin
          state_d = UART_DATA;
          cnt_d = FULL;
          bit_d = 3'h0;
        end
      end
      UART_DATA: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else begin
          shf_d = {rxLine, shf_q[7:1]};
          cnt_d = FULL;
          bit_d = bit_q + 1'b1;
          if (bit_q == 3'h7) begin
            state_d = UART_STOP;
            stop_d = 2'(STOP_BITS - 1);
            bad_d = 1'b0;
          end
        end
      end
      UART_STOP: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else begin
          cnt_d = FULL;
          if (stop_q == 2'h0) begin
            state_d = UART_IDLE;
            vld_d = 1'b1;
            data_d = shf_q;
            ferr_d = bad_q | ~rxLine;
          end else begin
            bad_d = bad_q | ~rxLine;
            stop_d = stop_q - 1'b1;
          end
        end
      end
      default: state_d = UART_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= UART_IDLE;
      cnt_q <= '0;
      bit_q <= 3'h0;
      stop_q <= 2'h0;
      shf_q <= 8'h00;
      data_q <= 8'h00;
      vld_q <= 1'b0;
      ferr_q <= 1'b0;
      bad_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      stop_q <= stop_d;
      shf_q <= shf_d;
      data_q <= data_d;
      vld_q <= vld_d;
      ferr_q <= ferr_d;
      bad_q <= bad_d;
    end
  end
  assign rxData = data_q;
  assign rxValid = vld_q;
  assign rxFrameErr = ferr_q;

  AST_VALID_PULSE: assert property (@(posedge clk_sys) disable iff (reset)
    rxValid |=> !rxValid)
    else $error("byte valid longer than one cycle");
  AST_FERR_WITH_VALID: assert property (@(posedge clk_sys) disable iff (reset)
    rxFrameErr |-> rxValid)
    else $error("framing error without byte");
endmodule

// [hw/asr_serial_rx_top.sv]
// avionics serial receive ports: two async receivers and a 429 word receiver
// What this block does
// - the transfer unit port takes 22.5 kbit/s characters of start, eight data, two stops.
// - the satellite port takes 4800 bit/s characters of start, eight data, one stop.
// - new characters go to the satellite unit only while its ready line is high.
// - the 429 input assembles 32-bit words and checks their odd parity bit.
// - a gap of four or more null bit periods delimits words and resets the bit count.
// - navigation labels 357,125,204,210,213,260,310,311,312,315,316 are accepted.
// - satellite variants also accept labels 304 and 270.
`timescale 1ns/100ps
`include "asr_regs.svh"
module asr_serial_rx_top #(
  parameter int DTU_BIT_CYCLES = (`ASR_CLK_HZ * 10) / `ASR_DTU_BAUD_X10,
  parameter int SAT_BIT_CYCLES = `ASR_CLK_HZ / `ASR_SAT_BAUD,
  parameter int A429_NULL_CYCLES = 64,
  parameter bit SAT_VARIANT = 1'b1
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic dataTransferRx,
  output asr_pkg::asr_byte_t dtuData,
  output logic dtuValid,
  output logic dtuFrameErr,
  input wire logic satelliteReceiveLine,
  output asr_pkg::asr_byte_t satData,
  output logic satValid,
  output logic satFrameErr,
  input wire logic satReadyIn,
  input wire logic satTxRequest,
  output logic satTxStartOk,
  input wire logic a429One,
  input wire logic a429Zero,
  output asr_pkg::asr_word_t a429Word,
  output logic a429Valid,
  output logic a429ParityErr
);
  import asr_pkg::*;
  asr_uart_rx #(.BIT_CYCLES(DTU_BIT_CYCLES), .STOP_BITS(`ASR_DTU_STOPS)) uDtu (
    .clk_sys(clk_sys),
    .reset(reset),
    .rxLine(dataTransferRx),
    .rxData(dtuData),
    .rxValid(dtuValid),
    .rxFrameErr(dtuFrameErr)
  );
  asr_uart_rx #(.BIT_CYCLES(SAT_BIT_CYCLES), .STOP_BITS(`ASR_SAT_STOPS)) uSat (
    .clk_sys(clk_sys),
    .reset(reset),
    .rxLine(satelliteReceiveLine),
    .rxData(satData),
    .rxValid(satValid),
    .rxFrameErr(satFrameErr)
  );
  assign satTxStartOk = satTxRequest & satReadyIn;

  // 429: a bit is a one or zero pulse; null is neither
  localparam int NW = $clog2(A429_NULL_CYCLES * `ASR_A429_GAP_NULLS + 1);
  // counted from the fall of the last pulse, so its return-to-zero half counts toward the gap
  localparam logic [NW-1:0] GAP = NW'(A429_NULL_CYCLES * `ASR_A429_GAP_NULLS);
  logic [NW-1:0] null_q, null_d;
  logic [5:0] cnt_q, cnt_d;
  asr_word_t shf_q, shf_d, word_q, word_d;
  logic prev_q, prev_d, vld_q, vld_d, perr_q, perr_d, sync_q, sync_d;
  logic bitHi, labelOk;
  logic [7:0] lbl;
  assign bitHi = a429One | a429Zero;
  assign lbl = shf_d[7:0];
  // accepted labels as one table; the satellite entries sit at the end
  localparam int NNAV = 11;
  localparam int NLBL = 13;
  localparam logic [7:0] LBL_TAB [NLBL] = '{
    `ASR_LBL_ISO5,
    `ASR_LBL_TIME,
    `ASR_LBL_ALT,
    `ASR_LBL_TAS,
    `ASR_LBL_SAT,
    `ASR_LBL_DATE,
    `ASR_LBL_LAT,
    `ASR_LBL_LON,
    `ASR_LBL_GS,
    `ASR_LBL_WSPD,
    `ASR_LBL_WDIR,
    `ASR_LBL_SATISO,
    `ASR_LBL_SDUSTAT
  };
  wire [NLBL-1:0] lblHit;
  for (genvar gi = 0; gi < NLBL; gi++) begin : gLbl
    if (gi < NNAV) begin : gNav
      assign lblHit[gi] = (lbl == LBL_TAB[gi]);
    end else begin : gSat
      // satellite label, only on that variant
      assign lblHit[gi] = SAT_VARIANT && (lbl == LBL_TAB[gi]);
    end
  end
  assign labelOk = |lblHit;
  always_comb begin
    null_d = null_q;
    cnt_d = cnt_q;
    shf_d = shf_q;
    word_d = word_q;
    sync_d = sync_q;
    prev_d = bitHi;
    vld_d = 1'b0;
    perr_d = 1'b0;
    if (bitHi) begin
      null_d = '0;
    end else if (null_q != GAP) begin
      null_d = null_q + 1'b1;
    end
    if (!bitHi && null_q == GAP - 1'b1) begin
      cnt_d = 6'h00;
      sync_d = 1'b1;
    end
    if (bitHi && !prev_q && sync_q) begin
      // first bit sent ends in bit 31; the last eight sent form the label in bits 7:0, msb first
      shf_d = {shf_q[30:0], a429One};
      cnt_d = cnt_q + 1'b1;
      if (cnt_q == 6'(`ASR_A429_BITS - 1)) begin
        cnt_d = 6'h00;
        sync_d = 1'b0;
        if (labelOk) begin
          vld_d = 1'b1;
          word_d = shf_d;
          perr_d = ~(^shf_d);
        end
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      null_q <= '0;
      cnt_q <= 6'h00;
      shf_q <= 32'h00000000;
      word_q <= 32'h00000000;
      prev_q <= 1'b0;
      vld_q <= 1'b0;
      perr_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      null_q <= null_d;
      cnt_q <= cnt_d;
      shf_q <= shf_d;
      word_q <= word_d;
      prev_q <= prev_d;
      vld_q <= vld_d;
      perr_q <= perr_d;
      sync_q <= sync_d;
    end
  end
  assign a429Word = word_q;
  assign a429Valid = vld_q;
  assign a429ParityErr = perr_q;

  AST_SAT_READY_GATE: assert property (@(posedge clk_sys) disable iff (reset)
    !satReadyIn |-> !satTxStartOk)
    else $error("start allowed while not ready");
  AST_SAT_GATE_PASS: assert property (@(posedge clk_sys) disable iff (reset)
    (satReadyIn && satTxRequest) |-> satTxStartOk)
    else $error("ready request not passed on");

  AST_A429_PAR: assert property (@(posedge clk_sys) disable iff (reset)
    a429Valid |-> (a429ParityErr == ~(^a429Word)))
    else $error("parity flag wrong");
  AST_A429_PULSE: assert property (@(posedge clk_sys) disable iff (reset)
    a429Valid |=> !a429Valid)
    else $error("word valid not a pulse");
  AST_A429_PERR_PULSE: assert property (@(posedge clk_sys) disable iff (reset)
    a429ParityErr |-> a429Valid)
    else $error("parity error without word");
  AST_A429_CNT_RANGE: assert property (@(posedge clk_sys) disable iff (reset)
    cnt_q < 6'(`ASR_A429_BITS))
    else $error("bit count past word length");
  // a word register that moves without its pulse would hand out torn words
  AST_A429_WORD_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
    $changed(a429Word) |-> a429Valid)
    else $error("word changed without valid");

  AST_A429_NOSYNC: assert property (@(posedge clk_sys) disable iff (reset)
    a429Valid |-> !sync_q)
    else $error("still synced after word");
  AST_A429_GAP_SYNC: assert property (@(posedge clk_sys) disable iff (reset)
    (null_q == GAP) |-> sync_q)
    else $error("full gap did not resynchronise");
  AST_A429_UNSYNC_IGNORE: assert property (@(posedge clk_sys) disable iff (reset)
    !sync_q |=> !a429Valid)
    else $error("word completed without sync");

  AST_DTU_SPACING: assert property (@(posedge clk_sys) disable iff (reset)
    dtuValid |=> !dtuValid [*8])
    else $error("transfer unit bytes too close");
  AST_DTU_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
    $changed(dtuData) |-> dtuValid)
    else $error("transfer unit byte changed without valid");
  AST_SAT_SPACING: assert property (@(posedge clk_sys) disable iff (reset)
    satValid |=> !satValid [*8])
    else $error("satellite bytes too close");
  AST_SAT_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
    $changed(satData) |-> satValid)
    else $error("satellite byte changed without valid");

  AST_LABEL_OK: assert property (@(posedge clk_sys) disable iff (reset)
    a429Valid |-> (a429Word[7:0] inside {`ASR_LBL_ISO5, `ASR_LBL_TIME, `ASR_LBL_ALT,
      `ASR_LBL_TAS, `ASR_LBL_SAT, `ASR_LBL_DATE, `ASR_LBL_LAT, `ASR_LBL_LON, `ASR_LBL_GS,
      `ASR_LBL_WSPD, `ASR_LBL_WDIR, `ASR_LBL_SATISO, `ASR_LBL_SDUSTAT}))
    else $error("unlisted label passed");
  AST_SAT_LBL: assert property (@(posedge clk_sys) disable iff (reset)
    (a429Valid && (a429Word[7:0] inside {`ASR_LBL_SATISO, `ASR_LBL_SDUSTAT})) |-> SAT_VARIANT)
    else $error("satellite label on plain variant");

  // main scenarios
  COV_DTU: cover property (@(posedge clk_sys) disable iff (reset) dtuValid && !dtuFrameErr);
  COV_SAT: cover property (@(posedge clk_sys) disable iff (reset) satValid);
  COV_A429: cover property (@(posedge clk_sys) disable iff (reset) a429Valid);
  COV_FERR: cover property (@(posedge clk_sys) disable iff (reset) dtuFrameErr);
  COV_A429_PERR: cover property (@(posedge clk_sys) disable iff (reset) a429ParityErr);
endmodule

// [tb/asr_far_units.sv]
// far-side model: transfer unit, satellite unit and navigation word source
`timescale 1ns/100ps
module asr_far_units #(
  parameter int DTU_BIT = 16,
  parameter int SAT_BIT = 24,
  parameter int NULL_CYC = 4
) (
  input wire logic clk_sys,
  output logic dtuLine,
  output logic satLine,
  output logic satReady,
  output logic a429One,
  output logic a429Zero
);
  initial begin
    dtuLine = 1'b1;
    satLine = 1'b1;
    satReady = 1'b0;
    a429One = 1'b0;
    a429Zero = 1'b0;
  end
  task automatic sendChar(input bit toSat, input logic [7:0] b, input int stops,
                          input bit badStop);
    logic [11:0] frame;
    int bc;
    frame = {3'b111, b, 1'b0};
    bc = toSat ? SAT_BIT : DTU_BIT;
    if (badStop) frame[8 + stops] = 1'b0;
    for (int i = 0; i < 9 + stops; i++) begin
      @(negedge clk_sys);
      if (toSat) satLine = frame[i];
      else dtuLine = frame[i];
      repeat (bc - 1) @(negedge clk_sys);
    end
    @(negedge clk_sys);
    dtuLine = 1'b1;
    satLine = 1'b1;
  endtask
  // ready level of the satellite unit
  task automatic setReady(input bit r);
    satReady = r;
  endtask
  // null gap, then 32 rz bits, word bit 31 first
  task automatic sendWord(input logic [31:0] w, input int gapCyc);
    repeat (gapCyc) @(negedge clk_sys);
    for (int i = 31; i >= 0; i--) begin
      a429One = w[i];
      a429Zero = !w[i];
      repeat (NULL_CYC) @(negedge clk_sys);
      a429One = 1'b0;
      a429Zero = 1'b0;
      repeat (NULL_CYC) @(negedge clk_sys);
    end
  endtask
endmodule

// [tb/asr_serial_rx_top_tb_top.sv]
// self-checking bench for the avionics serial receive ports
`timescale 1ns/100ps
module asr_serial_rx_top_tb_top;
  import asr_pkg::*;
  localparam int BITC = 16;
  localparam int SATC = 24;
  localparam int NULLC = 4;
  // a bit period is NULLC pulse cycles plus NULLC null cycles; the gap is four such periods
  localparam int GAPC = 8 * NULLC;
  localparam int LIMIT = 40000;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic satTxRequest = 1'b0;
  logic dtuLine, satLine, satReady, a429One, a429Zero;
  logic dtuValid, dtuFrameErr, satValid, satFrameErr, satTxStartOk, a429Valid, a429ParityErr;
  asr_byte_t dtuData, satData;
  asr_word_t a429Word;
  logic [32:0] dtuLast, satLast, wLast;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int dtuCnt = 0;
  int satCnt = 0;
  int wCnt = 0;
  logic [7:0] labels [13] = '{8'hEF, 8'h55, 8'h84, 8'h88, 8'h8B, 8'hB0, 8'hC8, 8'hC9, 8'hCA,
                              8'hCD, 8'hCE, 8'hC4, 8'hB8};

  asr_far_units #(.DTU_BIT(BITC), .SAT_BIT(SATC), .NULL_CYC(NULLC)) far_u (
    .clk_sys(clk_sys), .dtuLine(dtuLine), .satLine(satLine), .satReady(satReady),
    .a429One(a429One), .a429Zero(a429Zero));

  asr_serial_rx_top #(.DTU_BIT_CYCLES(BITC), .SAT_BIT_CYCLES(SATC),
                      .A429_NULL_CYCLES(2 * NULLC), .SAT_VARIANT(1'b1)) dut_u (
    .clk_sys(clk_sys), .reset(reset), .dataTransferRx(dtuLine), .dtuData(dtuData),
    .dtuValid(dtuValid), .dtuFrameErr(dtuFrameErr), .satelliteReceiveLine(satLine),
    .satData(satData), .satValid(satValid), .satFrameErr(satFrameErr),
    .satReadyIn(satReady), .satTxRequest(satTxRequest), .satTxStartOk(satTxStartOk),
    .a429One(a429One), .a429Zero(a429Zero), .a429Word(a429Word), .a429Valid(a429Valid),
    .a429ParityErr(a429ParityErr));

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic final_report();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // valid pulses stand one cycle, so latch them with their flags
  always @(posedge clk_sys) begin
    cycles++;
    if (dtuValid === 1'b1) begin
      dtuCnt++;
      dtuLast = {24'h0, dtuFrameErr, dtuData};
    end
    if (satValid === 1'b1) begin
      satCnt++;
      satLast = {24'h0, satFrameErr, satData};
    end
    if (a429Valid === 1'b1) begin
      wCnt++;
      wLast = {a429ParityErr, a429Word};
    end
    if (cycles == LIMIT) begin
      fails++;
      final_report();
    end
  end

  task automatic testUart(input bit toSat, input int stops);
    int c0;
    c0 = toSat ? satCnt : dtuCnt;
    far_u.sendChar(toSat, 8'hA5, stops, 1'b0);
    far_u.sendChar(toSat, 8'h01, stops, 1'b1);
    repeat (3) @(negedge clk_sys);
    check((toSat ? satCnt : dtuCnt) - c0, 2, "char count");
    check(toSat ? satLast : dtuLast, 33'h101, "bad stop char");
    far_u.sendChar(toSat, 8'h80, stops, 1'b0);
    repeat (3) @(negedge clk_sys);
    check(toSat ? satLast : dtuLast, 33'h080, "good char");
    $display("uart test done sat=%0d", toSat);
  endtask

  task automatic testReady();
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_sys);
      satTxRequest = i[0];
      far_u.setReady(i[1]);
      #1;
      check(satTxStartOk, i[0] & i[1], "start gate");
    end
    satTxRequest = 1'b0;
    $display("ready test done");
  endtask

  task automatic word(input logic [31:0] w, input int gapCyc, input int n, input bit pe);
    int c0;
    c0 = wCnt;
    far_u.sendWord(w, gapCyc);
    repeat (2) @(negedge clk_sys);
    check(wCnt - c0, n, "word count");
    if (n == 1) check(wLast, {pe, w}, "word");
  endtask

  task automatic testWords();
    logic [31:0] w;
    for (int i = 0; i < 13; i++) begin
      w = {1'b0, 23'h2A5C3 ^ 23'(i), labels[i]};
      if (^w == 1'b0) w[31] = 1'b1;
      word(w, GAPC, 1, 1'b0);
    end
    word(w ^ 32'h8000_0000, GAPC, 1, 1'b1);
    word(32'h8000_0000, GAPC, 0, 1'b0);
    // too short a gap after a word leaves the whole next word ignored
    word(w, NULLC, 0, 1'b0);
    word(w, GAPC, 1, 1'b0);
    $display("word test done");
  endtask

  initial begin
    repeat (20) @(negedge clk_sys);
    reset = 1'b0;
    repeat (2) @(negedge clk_sys);
    testUart(1'b0, 2);
    testUart(1'b1, 1);
    testReady();
    testWords();
    final_report();
  end
endmodule
